// ---- hdl/gpint_pkg.sv ----
// Package for the port block: register map, field positions, reset values and carrier types
package gpint_pkg;
   localparam logic [7:0] GPINT_OFS_DATA = 8'h00;
   localparam logic [7:0] GPINT_OFS_DIR = 8'h04;
   localparam logic [7:0] GPINT_OFS_INTCTL = 8'h08;
   localparam logic [7:0] GPINT_OFS_OPTION = 8'h0C;
   localparam logic [7:0] GPINT_OFS_ANALOG = 8'h10;
   localparam int GPINT_CHG_FLAG_BIT = 0;
   localparam int GPINT_EXT_FLAG_BIT = 1;
   localparam int GPINT_CHG_EN_BIT = 3;
   localparam int GPINT_EXT_EN_BIT = 4;
   localparam int GPINT_GIE_BIT = 7;
   localparam int GPINT_EDGE_BIT = 6;
   localparam int GPINT_PULLUP_BIT = 7;
   localparam int GPINT_MASTER_CLEAR_PIN = 3;
   localparam int GPINT_EXT_PIN = 2;
   localparam int GPINT_INSTR_CLOCK_OUTPUT_PIN = 4;
   localparam int GPINT_OSC_PIN = 5;
   localparam logic [7:0] GPINT_DIR_RESET = 8'hFF;
   localparam logic [7:0] GPINT_INTCTL_RESET = 8'h00;
   localparam logic [7:0] GPINT_OPTION_RESET = 8'hFF;
   localparam logic [3:0] GPINT_ANALOG_RESET = 4'hF;
   localparam logic [7:0] GPINT_LATCH_RESET = 8'h00;
   localparam logic [7:0] GPINT_INTCTL_WMASK = 8'h9B;
   localparam logic [2:0] GPINT_CHG_PINS = 3'b111;

   typedef enum logic [2:0] {OSC_LP, OSC_XT, OSC_HS, OSC_EXTERNAL_RC_OSC_MODE, OSC_INTERNAL_RC_OSC_MODE} gpint_osc_type;

   typedef struct packed {
      gpint_osc_type oscMode;
      logic masterClear;
      logic clockOut;
   } gpint_cfg_type;

   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } gpint_apb_req_type;
endpackage

// ---- hdl/gpint_port.sv ----
// General purpose port with weak pull-ups, change interrupt and edge interrupt, APB slave
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/10ps

// Function
// RULE1: Port read returns pin levels, not latch
// RULE2: Reset sets every direction bit to one
// RULE3: Eight-bit port, six external, two internal
// RULE4: Pin 3 input only, direction reads one
// RULE5: Direction bits 6 and 7 read zero
// RULE6: Alternate-function pins read zero
// RULE7: Direction one tristates, zero drives latch
// RULE8: Pull-ups and change on pins 0,1,3, shared
// RULE9: Master clear pin: pull-up on, no change, zero
// RULE10: Oscillator modes own pins 4,5 direction writes
// RULE11: Clock output ignores direction bit 4 writes
// RULE12: Latches hold; inputs sampled, not latched
// RULE13: Analog pins after reset, read zero
// RULE14: Analog reconfiguration may set both flags
// RULE15: External pin edge chosen by option bit 6
// RULE16: Edge sets flag bit 1, bit 4 enables
// RULE17: Software clears external flag; hardware never
// RULE18: External interrupt wakes core from sleep
// RULE19: Change on pins 3,1,0 sets flag bit 0
// RULE20: Software avoids writing internal pins 6,7
// RULE21: Change compares against last-read levels
// RULE22: Request needs flag, enable and global enable
module gpint_port
   import gpint_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Configuration word
   input wire gpint_cfg_type cfgWord,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins
   input wire logic [7:0] pinIn,
   output logic [7:0] pinOut,
   output logic [7:0] pinOe,
   output logic [2:0] pullUpOn,
   // Core interface
   input wire logic sleepMode,
   output logic intRequest,
   output logic wakeUp
);
   ////////////////////////////////////////////////////////////////////////////////
   // Registers
   gpint_cfg_type cfg_q;
   logic [7:0] sync1_q, sync2_q, sync3_q, pins_q;
   logic [7:0] latch_q, dir_q, intctl_q, option_q;
   logic [3:0] analog_q;
   logic [2:0] snap_q;
   logic extPrev_q;
   logic [1:0] div_q;
   logic [31:0] prdata_q;
   logic pready_q, pslverr_q, irq_q, wake_q;
   logic [7:0] pinOut_q, pinOe_q;
   logic [2:0] pullUp_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode
   gpint_apb_req_type req;
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   wire setup = req.sel && !req.enable;
   wire access = req.sel && req.enable && pready_q;
   wire wr = access && req.write;
   wire rd = access && !req.write;
   wire hitData = (req.addr == GPINT_OFS_DATA);
   wire hitDir = (req.addr == GPINT_OFS_DIR);
   wire hitInt = (req.addr == GPINT_OFS_INTCTL);
   wire hitOpt = (req.addr == GPINT_OFS_OPTION);
   wire hitAna = (req.addr == GPINT_OFS_ANALOG);
   wire mapped = hitData || hitDir || hitInt || hitOpt || hitAna;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin functions
   wire mclrMode = cfg_q.masterClear;
   wire oscPin4Port = (cfg_q.oscMode == OSC_EXTERNAL_RC_OSC_MODE) || (cfg_q.oscMode == OSC_INTERNAL_RC_OSC_MODE);
   wire oscPin5Port = (cfg_q.oscMode == OSC_INTERNAL_RC_OSC_MODE);
   wire clkOutMode = cfg_q.clockOut && oscPin4Port;
   wire dirWrAllowed = oscPin4Port;
   // Alternate functions mask pin reads
   wire [7:0] altMask = {2'b00, !oscPin5Port, !oscPin4Port || clkOutMode || analog_q[3],
      mclrMode, analog_q[2], analog_q[1], analog_q[0]}; // RULE6 RULE9 RULE13
   wire [7:0] portRead = pins_q & ~altMask; // RULE1 RULE6
   wire [7:0] dirRead = {2'b00, dir_q[5:4], 1'b1, dir_q[2:0]}; // RULE4 RULE5
   wire [7:0] dirEff = {dir_q[7:6], dirWrAllowed ? dir_q[5:4] : 2'b11, 1'b1, dir_q[2:0]};
   wire [2:0] chgNow = {portRead[3], portRead[1], portRead[0]};
   wire [2:0] chgMask = {!mclrMode, 2'b11} & GPINT_CHG_PINS; // RULE9
   wire chgEvent = |((chgNow ^ snap_q) & chgMask); // RULE19 RULE21 RULE14
   wire extNow = portRead[GPINT_EXT_PIN];
   wire edgeSel = option_q[GPINT_EDGE_BIT];
   wire extEvent = edgeSel ? (extNow && !extPrev_q) : (!extNow && extPrev_q); // RULE15 RULE14
   wire [7:0] dirWrite = {req.wdata[7:5], clkOutMode ? dir_q[4] : req.wdata[4],
      1'b1, req.wdata[2:0]};
   wire [7:0] dirNext = {dirWrite[7:6], dirWrAllowed ? dirWrite[5:4] : dir_q[5:4],
      dirWrite[3:0]}; // RULE10 RULE11
   wire [7:0] intWr = (intctl_q & ~GPINT_INTCTL_WMASK) | (req.wdata[7:0] & GPINT_INTCTL_WMASK);
   wire [7:0] intBase = (wr && hitInt) ? intWr : intctl_q; // RULE17
   wire [7:0] intNext = intBase | {6'h00, extEvent, chgEvent}; // RULE16 RULE19
   wire chgReq = intctl_q[GPINT_CHG_FLAG_BIT] && intctl_q[GPINT_CHG_EN_BIT];
   wire extReq = intctl_q[GPINT_EXT_FLAG_BIT] && intctl_q[GPINT_EXT_EN_BIT];
   wire irqNext = (chgReq || extReq) && intctl_q[GPINT_GIE_BIT]; // RULE22
   wire wakeNext = sleepMode && extReq; // RULE18
   wire pullShared = option_q[GPINT_PULLUP_BIT];
   wire [31:0] readMux = hitData ? {24'h00_0000, portRead} :
      hitDir ? {24'h00_0000, dirRead} :
      hitInt ? {24'h00_0000, intctl_q} :
      hitOpt ? {24'h00_0000, option_q} :
      hitAna ? {28'h000_0000, analog_q} : 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration and pin synchroniser
   always_ff @(posedge clk)
   begin
      if (!rstn)
         cfg_q <= cfgWord;
   end

   always_ff @(posedge clk)
   begin
      sync1_q <= pinIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      if (!rstn)
         pins_q <= sync3_q;
      else if (sync2_q == sync3_q)
         pins_q <= sync3_q; // RULE12
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software registers
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         latch_q <= GPINT_LATCH_RESET;
         dir_q <= GPINT_DIR_RESET; // RULE2
         intctl_q <= GPINT_INTCTL_RESET;
         option_q <= GPINT_OPTION_RESET;
         analog_q <= GPINT_ANALOG_RESET; // RULE13
      end
      else
      begin
         if (wr && hitData)
            latch_q <= req.wdata[7:0]; // RULE12 RULE3
         if (wr && hitDir)
            dir_q <= dirNext;
         if (wr && hitOpt)
            option_q <= req.wdata[7:0];
         if (wr && hitAna)
            analog_q <= req.wdata[3:0];
         intctl_q <= intNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Change snapshot, edge history, clock divider
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         snap_q <= chgNow;
         extPrev_q <= extNow;
         div_q <= 2'b00;
      end
      else
      begin
         if (rd && hitData)
            snap_q <= chgNow; // RULE21
         extPrev_q <= extNow;
         div_q <= div_q + 2'b01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers and interrupt outputs
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pinOut_q <= 8'h00;
         pinOe_q <= 8'h00;
         pullUp_q <= 3'b000;
         irq_q <= 1'b0;
         wake_q <= 1'b0;
      end
      else
      begin
         pinOut_q <= {latch_q[7:5], clkOutMode ? div_q[1] : latch_q[4], latch_q[3:0]};
         pinOe_q <= ~dirEff | {3'b000, clkOutMode, 4'h0}; // RULE7
         pullUp_q <= {mclrMode || pullShared, pullShared, pullShared}; // RULE8 RULE9
         irq_q <= irqNext;
         wake_q <= wakeNext;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // APB answer
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end
      else
      begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         if (setup)
            prdata_q <= req.write ? 32'h0000_0000 : readMux;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign pinOut = pinOut_q;
   assign pinOe = pinOe_q;
   assign pullUpOn = pullUp_q;
   assign intRequest = irq_q;
   assign wakeUp = wake_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   dir3_read_a: assert property (dirRead[GPINT_MASTER_CLEAR_PIN] && dirRead[7:6] == 2'b00) // RULE4
      else $error("direction readback wrong on pins 3, 6 or 7");
   dir_reset_a: assert property ($rose(rstn) |-> dir_q == GPINT_DIR_RESET) // RULE2
      else $error("direction not all ones after reset");
   pin_drive_a: assert property (dirEff[0] |=> !pinOe_q[0]) // RULE7
      else $error("pin 0 driven while direction is one");
   drive_value_a: assert property (!dirEff[1] |=> pinOe_q[1] && pinOut_q[1] == $past(latch_q[1]))
      else $error("pin 1 not driving latch"); // RULE7
   instr_clock_output_dir_a: assert property (wr && hitDir && clkOutMode |=> $stable(dir_q[4])) // RULE11
      else $error("direction bit 4 changed under clock output");
   osc_dir_a: assert property (wr && hitDir && !dirWrAllowed |=> $stable(dir_q[5:4])) // RULE10
      else $error("direction 5:4 changed in crystal mode");
   alt_read_a: assert property (analog_q[0] |-> portRead[0] == 1'b0) // RULE13
      else $error("analog pin 0 read nonzero");
   master_clear_read_a: assert property (mclrMode |-> !portRead[3] && !chgMask[2]) // RULE9
      else $error("master clear pin visible");
   chg_set_a: assert property (chgEvent |=> intctl_q[GPINT_CHG_FLAG_BIT]) // RULE19
      else $error("change flag not set");
   ext_set_a: assert property (extEvent |=> intctl_q[GPINT_EXT_FLAG_BIT]) // RULE16
      else $error("external flag not set");
   ext_hold_a: assert property (intctl_q[1] && !(wr && hitInt) |=> intctl_q[1]) // RULE17
      else $error("external flag cleared by hardware");
   irq_gate_a: assert property (irqNext |=> intRequest) // RULE22
      else $error("request not raised");
   irq_gie_a: assert property (!intctl_q[GPINT_GIE_BIT] |=> !intRequest) // RULE22
      else $error("request without global enable");
   wake_a: assert property (sleepMode && extReq |=> wakeUp) // RULE18
      else $error("no wake from sleep");

   read_pins_a: assert property (setup && !req.write && hitData |=> // RULE1
      prdata[7:0] == ($past(pins_q) & ~$past(altMask))) else $error("port read not pins");

   dir_high_a: assert property (setup && !req.write && hitDir |=> prdata[7:6] == 2'b00) // RULE5
      else $error("direction bits 7:6 read nonzero");

   dir_pin3_a: assert property (setup && !req.write && hitDir |=> prdata[3]) // RULE4
      else $error("direction bit 3 read zero");

   pin3_oe_a: assert property (!pinOe[GPINT_MASTER_CLEAR_PIN]) // RULE4
      else $error("pin 3 driven");

   upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000) // RULE3
      else $error("read data above bit 7 nonzero");

   osc5_read_a: assert property (!oscPin5Port |-> !portRead[GPINT_OSC_PIN]) // RULE10
      else $error("oscillator pin 5 read nonzero");

   osc4_read_a: assert property (!oscPin4Port |-> !portRead[GPINT_INSTR_CLOCK_OUTPUT_PIN]) // RULE10
      else $error("oscillator pin 4 read nonzero");

   clk_read_a: assert property (clkOutMode |-> !portRead[GPINT_INSTR_CLOCK_OUTPUT_PIN]) // RULE6
      else $error("clock output pin read nonzero");

   clk_oe_a: assert property (clkOutMode |=> pinOe[GPINT_INSTR_CLOCK_OUTPUT_PIN]) // RULE11
      else $error("clock output pin not driven");

   osc_oe_a: assert property (!oscPin4Port |=> !pinOe[5] && !pinOe[4]) // RULE10
      else $error("oscillator pins driven");

   latch_hold_a: assert property (!(wr && hitData) |=> $stable(latch_q)) // RULE12
      else $error("output latch changed without write");

   latch_write_a: assert property (wr && hitData |=> latch_q == $past(req.wdata[7:0])) // RULE3
      else $error("output latch write lost");

   dir_hold_a: assert property (!(wr && hitDir) |=> $stable(dir_q)) // RULE7
      else $error("direction changed without write");

   analog_read_a: assert property ((portRead & altMask) == 8'h00) // RULE13
      else $error("analog pin read nonzero");

   analog_reset_a: assert property ($rose(rstn) |-> analog_q == GPINT_ANALOG_RESET) // RULE13
      else $error("analog config not reset");

   pull_shared_a: assert property (pullUpOn[1] == pullUpOn[0]) // RULE8
      else $error("pull-ups on pins 0 and 1 differ");

   pull_master_clear_a: assert property (mclrMode |=> pullUpOn[2]) // RULE9
      else $error("master clear pull-up off");

   pull_off_a: assert property (!pullShared && !mclrMode |=> pullUpOn == 3'b000) // RULE8
      else $error("pull-up on while disabled");

   ext_rise_a: assert property (edgeSel && $rose(extNow) |=> intctl_q[1]) // RULE15
      else $error("rising edge missed");

   ext_fall_a: assert property (!edgeSel && $fell(extNow) |=> intctl_q[1]) // RULE15
      else $error("falling edge missed");

   ext_nofall_a: assert property (edgeSel && $fell(extNow) && !intctl_q[1] && // RULE15
      !(wr && hitInt) |=> !intctl_q[1]) else $error("flag set on falling edge");

   ext_norise_a: assert property (!edgeSel && $rose(extNow) && !intctl_q[1] && // RULE15
      !(wr && hitInt) |=> !intctl_q[1]) else $error("flag set on rising edge");

   chg_quiet_a: assert property (!chgEvent && !intctl_q[0] && !(wr && hitInt) // RULE21
      |=> !intctl_q[0]) else $error("change flag set without change");

   chg_hold_a: assert property (intctl_q[0] && !(wr && hitInt) |=> intctl_q[0]) // RULE19
      else $error("change flag cleared by hardware");

   gie_write_a: assert property (wr && hitInt |=> intctl_q[7] == $past(req.wdata[7])) // RULE22
      else $error("global enable write lost");

   int_zero_a: assert property (!intctl_q[2] && intctl_q[6:5] == 2'b00) // RULE16
      else $error("unused control bits set");

   wake_off_a: assert property (!sleepMode |=> !wakeUp) // RULE18
      else $error("wake while awake");

   irq_src_a: assert property (intRequest |-> $past(intctl_q[GPINT_GIE_BIT])) // RULE22
      else $error("request without prior global enable");

   wake_src_a: assert property (wakeUp |-> $past(intctl_q[GPINT_EXT_EN_BIT])) // RULE18
      else $error("wake without external enable");

   snap_load_a: assert property (rd && hitData |=> snap_q == $past(chgNow)) // RULE21
      else $error("snapshot not taken at read");

   snap_hold_a: assert property (!(rd && hitData) |=> $stable(snap_q)) // RULE21
      else $error("snapshot moved without read");

   dir_osc_a: assert property (wr && hitDir && dirWrAllowed && !clkOutMode |=> // RULE10
      dir_q[5:4] == $past(req.wdata[5:4])) else $error("direction 5:4 write lost");

   dir_low_a: assert property (wr && hitDir |=> dir_q[2:0] == $past(req.wdata[2:0])) // RULE7
      else $error("direction 2:0 write lost");

   dir_bit3_a: assert property (dir_q[GPINT_MASTER_CLEAR_PIN]) // RULE4
      else $error("direction bit 3 cleared");

   pin6_oe_a: assert property (dirEff[6] |=> !pinOe[6]) // RULE7
      else $error("pin 6 driven while direction is one");
endmodule

// ---- verification/gpint_pin_model.sv ----
// Pin-side model: outside circuitry, pull-ups and floating lines
`timescale 1ns/10ps
module gpint_pin_model (
   // Clock
   input wire logic clk,
   // Port side
   input wire logic [7:0] pinOut,
   input wire logic [7:0] pinOe,
   input wire logic [2:0] pullUpOn,
   // Outside drivers
   input wire logic [7:0] extVal,
   input wire logic [7:0] extDrv,
   // Resolved pins
   output logic [7:0] pinIn
);
   logic [7:0] float_q;
   logic [7:0] pull;
   initial float_q = 8'h5A;
   always @(posedge clk) float_q <= ~float_q;
   // Pull-ups on pins 0, 1, 3 only
   assign pull = {4'h0, pullUpOn[2], 1'b0, pullUpOn[1:0]};
   // Outside level is held by the bench until it changes extVal
   assign pinIn = (pinOe & pinOut) | (~pinOe & extDrv & extVal)
      | (~pinOe & ~extDrv & (pull | float_q));
endmodule

// ---- verification/tb_top.sv ----
// Bench for the port block
`timescale 1ns/10ps
module tb_top
   import gpint_pkg::*;
;
   logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, sleepMode = 0;
   logic [7:0] paddr = 8'h00, extVal = 8'hFF, extDrv = 8'hFF;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, intRequest, wakeUp, err;
   logic [7:0] pinIn, pinOut, pinOe;
   logic [2:0] pullUpOn;
   gpint_cfg_type cfgWord = '{oscMode: OSC_INTERNAL_RC_OSC_MODE, masterClear: 1'b0, clockOut: 1'b0};
   int errorCnt = 0, checks = 0;
   gpint_port i_gpint_port (.clk(clk), .rstn(rstn), .cfgWord(cfgWord), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
      .pullUpOn(pullUpOn), .sleepMode(sleepMode), .intRequest(intRequest), .wakeUp(wakeUp));
   gpint_pin_model i_gpint_pin_model (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
      .pullUpOn(pullUpOn), .extVal(extVal), .extDrv(extDrv), .pinIn(pinIn));
   initial forever #10 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      if (errorCnt == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task ck(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      for (i = 0; i < 10; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 10)
      begin
         errorCnt++;
         print_verdict();
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1, a, {24'h00_0000, d});
   endtask
   task rc(input logic [7:0] a, input logic [7:0] e);
      apb(0, a, 32'h0000_0000);
      ck("read", {24'h00_0000, e}, rd);
   endtask
   task settle;
      repeat (8) @(posedge clk);
   endtask
   task rst;
      rstn <= 0;
      repeat (20) @(posedge clk);
      rstn <= 1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst();
      rc(GPINT_OFS_DIR, 8'h3F);
      rc(GPINT_OFS_INTCTL, 8'h00);
      rc(GPINT_OFS_OPTION, 8'hFF);
      rc(GPINT_OFS_ANALOG, 8'h0F);
      ck("oe", 8'h00, pinOe);
      ck("pullup", 3'b111, pullUpOn);
      rc(GPINT_OFS_DATA, 8'hE8);
      apb(0, 8'h14, 32'h0000_0000);
      ck("slverr", 32'h0000_0001, {rd[30:0], err});
      wr(GPINT_OFS_ANALOG, 8'h00);
      wr(GPINT_OFS_DIR, 8'h00);
      rc(GPINT_OFS_DIR, 8'h08);
      wr(GPINT_OFS_DATA, 8'h15);
      settle();
      ck("oe", 8'hF7, pinOe);
      ck("out", 8'h15, pinOut);
      rc(GPINT_OFS_DATA, 8'h1D);
      wr(GPINT_OFS_DIR, 8'hFF);
      settle();
      rc(GPINT_OFS_DATA, 8'hFF);
      wr(GPINT_OFS_INTCTL, 8'h00);
      rc(GPINT_OFS_INTCTL, 8'h00);
      wr(GPINT_OFS_INTCTL, 8'h88);
      extVal <= 8'hFE;
      settle();
      rc(GPINT_OFS_INTCTL, 8'h89);
      ck("irq", 1, intRequest);
      rc(GPINT_OFS_DATA, 8'hFE);
      wr(GPINT_OFS_INTCTL, 8'h08);
      rc(GPINT_OFS_INTCTL, 8'h08);
      ck("irq", 0, intRequest);
      extVal <= 8'hFA;
      settle();
      rc(GPINT_OFS_INTCTL, 8'h08);
      extVal <= 8'hFE;
      settle();
      rc(GPINT_OFS_INTCTL, 8'h0A);
      sleepMode <= 1;
      wr(GPINT_OFS_INTCTL, 8'h1A);
      settle();
      ck("wake", 1, wakeUp);
      ck("irq", 0, intRequest);
      sleepMode <= 0;
      wr(GPINT_OFS_OPTION, 8'hBF);
      wr(GPINT_OFS_INTCTL, 8'h10);
      extVal <= 8'hFA;
      settle();
      rc(GPINT_OFS_INTCTL, 8'h12);
      cfgWord <= '{oscMode: OSC_EXTERNAL_RC_OSC_MODE, masterClear: 1'b1, clockOut: 1'b1};
      extVal <= 8'hFF;
      rst();
      settle();
      ck("pullup", 1, pullUpOn[2]);
      wr(GPINT_OFS_ANALOG, 8'h00);
      settle();
      rc(GPINT_OFS_DATA, 8'hC7);
      wr(GPINT_OFS_DIR, 8'h00);
      rc(GPINT_OFS_DIR, 8'h18);
      wr(GPINT_OFS_OPTION, 8'h7F);
      settle();
      ck("pullup", 3'b100, pullUpOn);
      cfgWord <= '{oscMode: OSC_LP, masterClear: 1'b0, clockOut: 1'b1};
      rst();
      wr(GPINT_OFS_DIR, 8'h00);
      rc(GPINT_OFS_DIR, 8'h38);
      settle();
      ck("oe", 8'hC7, pinOe);
      print_verdict();
   end
endmodule
